// >>> rtl/bus_cfg.sv
`timescale 1ns/1ps
// Contract
// - slave disable bit 6 resets to one
// - restart permission bit 5 gates repeated starts
// - bit 4 picks master 7/10-bit addressing
// - bit 3 picks slave 7/10-bit addressing
// - speed field: 1 standard, 2 fast
// - bit 0 enables master role
// - special bit 11 selects special command
// - bit 10: general call or start byte
// - read after general call sets abort flag
// - general call holds until special cleared or bit 10 set
// - target field addresses master, ignored for call
// - self address loopback simplex only
// - target writes only while controller off
// - target resets to 0x55, special bits zero
// - seven-bit mode matches own address low bits
// - no restart permitted: stop then start
module bus_cfg
  import bus_cfg_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        RESTART_REQ,
  input  wire logic [9:0]  BUS_ADDR_SEEN,
  input  wire logic        BUS_ADDR_WIDE,
  output logic             SLAVE_ON,
  output logic             MASTER_ON,
  output logic             RESTART_OK,
  output logic             STOP_START,
  output logic             MASTER_WIDE,
  output logic             SLAVE_WIDE,
  output logic [1:0]       SPEED_MODE,
  output logic [9:0]       DEST_ADDR,
  output logic             SEND_BCAST,
  output logic             SEND_STARTBYTE,
  output logic             SELF_MATCH,
  output logic             SIMPLEX_ONLY
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] bus_control;
    logic [15:0] target_address;
    logic [9:0]  own_addr;
    logic        controller_on;
    logic        send_abort_flag;
    logic        restart_ok;
    logic        stop_start;
    logic [9:0]  dest_addr;
    logic        send_bcast;
    logic        send_startbyte;
    logic        self_match;
    logic        simplex_only;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = d[7:0];
    if (be[1]) v[15:8] = d[15:8];
    return v & m;
  endfunction

  function automatic logic own_match(input logic [9:0] seen, input logic [9:0] own,
                                     input logic wide);
    return wide ? (seen == own) : (seen[6:0] == own[6:0]);
  endfunction

  logic        do_write;
  logic        do_read;
  logic        gc_mode;
  logic [31:0] rd;
  logic        rd_ok;
  logic        wr_ok;
  logic [15:0] own_new;

  always_comb begin
    next_s = s;
    own_new = 16'h0000;
    do_write = s.aw_held && s.w_held && !s.bvalid;
    do_read  = ARVALID && !s.rvalid;
    gc_mode  = s.target_address[SPECIAL_BIT] && !s.target_address[BCAST_BIT];
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    // ****************************************
    // write channel
    // ****************************************
    if (AWVALID && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      case (s.aw_addr)
        BUS_CONTROL_ADDR:
          next_s.bus_control = merge16(s.bus_control, s.w_data, s.w_strb, CTRL_MASK);
        TARGET_ADDRESS_ADDR:
          if (!s.controller_on)
            next_s.target_address = merge16(s.target_address, s.w_data, s.w_strb,
                                            TAR_MASK);
        OWN_ADDR_ADDR:
          if (!s.controller_on) begin
            own_new = merge16({6'h00, s.own_addr}, s.w_data, s.w_strb, TAR_MASK);
            next_s.own_addr = own_new[9:0];
          end
        CONTROLLER_ON_ADDR:
          if (s.w_strb[0]) next_s.controller_on = s.w_data[0];
        RAW_EVENT_ADDR:
          if (s.w_strb[0] && s.w_data[ABORT_BIT]) next_s.send_abort_flag = 1'b0;
        CMD_PORT_ADDR:
          wr_ok = 1'b1;
        default:
          wr_ok = 1'b0;
      endcase
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    // read command after general call aborts; set wins over clear
    if (do_write && s.aw_addr == CMD_PORT_ADDR && s.w_data[CMD_READ_BIT] && gc_mode)
      next_s.send_abort_flag = 1'b1;
    // ****************************************
    // read channel
    // ****************************************
    case (ARADDR)
      BUS_CONTROL_ADDR:    rd = {16'h0000, s.bus_control};
      TARGET_ADDRESS_ADDR: rd = {16'h0000, s.target_address};
      OWN_ADDR_ADDR:       rd = {22'h00_0000, s.own_addr};
      CONTROLLER_ON_ADDR:  rd = {31'h0000_0000, s.controller_on};
      RAW_EVENT_ADDR:      rd = {25'h000_0000, s.send_abort_flag, 6'h00};
      default:             rd_ok = 1'b0;
    endcase
    if (do_read) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd;
      next_s.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    // ****************************************
    // derived controls
    // ****************************************
    next_s.restart_ok = s.bus_control[RESTART_BIT];
    next_s.stop_start = RESTART_REQ && !s.bus_control[RESTART_BIT];
    next_s.send_bcast = gc_mode;
    next_s.send_startbyte = s.target_address[SPECIAL_BIT] && s.target_address[BCAST_BIT];
    if (!s.target_address[SPECIAL_BIT])
      next_s.dest_addr = s.target_address[9:0];
    else if (s.target_address[BCAST_BIT])
      next_s.dest_addr = {3'h0, SBYTE_ADDR};
    else
      next_s.dest_addr = {3'h0, BCAST_ADDR};
    next_s.self_match = own_match(BUS_ADDR_SEEN, s.own_addr, BUS_ADDR_WIDE
                                  && s.bus_control[RESP_WIDE_BIT]);
    next_s.simplex_only = s.bus_control[MST_EN_BIT] && !s.target_address[SPECIAL_BIT]
                          && (s.target_address[9:0] == s.own_addr);
    if (!NRST) begin
      next_s = '0;
      next_s.bus_control    = CTRL_RESET;
      next_s.target_address = TAR_RESET;
      next_s.own_addr       = OWN_RESET;
      next_s.restart_ok     = 1'b1;
      next_s.dest_addr      = TAR_RESET[9:0];
    end
    // ****************************************
    // ready flags, registered
    // ****************************************
    next_s.aw_rdy = !next_s.aw_held;
    next_s.w_rdy  = !next_s.w_held;
    next_s.ar_rdy = !next_s.rvalid;
  end

  always_ff @(posedge REF_CLK) begin
    s <= next_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign AWREADY = s.aw_rdy;
  assign WREADY  = s.w_rdy;
  assign BVALID  = s.bvalid;
  assign BRESP   = s.bresp;
  assign ARREADY = s.ar_rdy;
  assign RVALID  = s.rvalid;
  assign RDATA   = s.rdata;
  assign RRESP   = s.rresp;
  assign SLAVE_ON    = !s.bus_control[SLV_OFF_BIT];
  assign MASTER_ON   = s.bus_control[MST_EN_BIT];
  assign MASTER_WIDE = s.bus_control[INIT_WIDE_BIT];
  assign SLAVE_WIDE  = s.bus_control[RESP_WIDE_BIT];
  assign SPEED_MODE  = s.bus_control[SPEED_HI:SPEED_LO];
  assign RESTART_OK  = s.restart_ok;
  assign STOP_START  = s.stop_start;
  assign DEST_ADDR   = s.dest_addr;
  assign SEND_BCAST  = s.send_bcast;
  assign SEND_STARTBYTE = s.send_startbyte;
  assign SELF_MATCH  = s.self_match;
  assign SIMPLEX_ONLY = s.simplex_only;

  // ****************************************
  // checks
  // ****************************************
  sequence tar_wr_on_s;
    do_write && s.aw_addr == TARGET_ADDRESS_ADDR && s.controller_on;
  endsequence

  tar_locked_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    tar_wr_on_s |=> $stable(s.target_address))
    else $error("target written while controller on");

  slv_reset_a: assert property (@(posedge REF_CLK)
    !NRST |=> SLAVE_ON == 1'b0)
    else $error("slave on after reset");

  tar_reset_a: assert property (@(posedge REF_CLK)
    !NRST |=> s.target_address == TAR_RESET)
    else $error("target reset wrong");

  abort_set_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (do_write && s.aw_addr == CMD_PORT_ADDR && s.w_data[CMD_READ_BIT] && gc_mode)
    |=> s.send_abort_flag)
    else $error("abort flag not set");

  stop_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (RESTART_REQ && !s.bus_control[RESTART_BIT]) |=> STOP_START)
    else $error("stop start missing");

  bcast_addr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 (SEND_BCAST && $stable(s.target_address)) |-> DEST_ADDR == {3'h0, BCAST_ADDR})
    else $error("call address wrong");

  rsv_zero_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (s.bus_control & ~CTRL_MASK) == 16'h0000 && (s.target_address & ~TAR_MASK) == 16'h0000)
    else $error("reserved bits set");

  simplex_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 (MASTER_ON && !s.target_address[SPECIAL_BIT] && s.target_address[9:0] == s.own_addr
    && $stable(s.target_address) && $stable(s.own_addr) && $stable(s.bus_control))
    |-> SIMPLEX_ONLY)
    else $error("simplex flag missing");

  sequence ctrl_wr_s;
    do_write && s.aw_addr == BUS_CONTROL_ADDR && s.w_strb == 4'hF;
  endsequence

  sequence tar_wr_off_s;
    do_write && s.aw_addr == TARGET_ADDRESS_ADDR && !s.controller_on && s.w_strb == 4'hF;
  endsequence

  ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_wr_s |=> s.bus_control == ($past(s.w_data[15:0]) & CTRL_MASK))
    else $error("control write wrong");

  slave_on_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_wr_s |=> SLAVE_ON == !$past(s.w_data[SLV_OFF_BIT]))
    else $error("slave enable wrong");

  master_on_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_wr_s |=> MASTER_ON == $past(s.w_data[MST_EN_BIT]))
    else $error("master enable wrong");

  speed_mode_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_wr_s |=> SPEED_MODE == $past(s.w_data[SPEED_HI:SPEED_LO]))
    else $error("speed field wrong");

  addr_wide_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ctrl_wr_s |=> MASTER_WIDE == $past(s.w_data[INIT_WIDE_BIT])
    && SLAVE_WIDE == $past(s.w_data[RESP_WIDE_BIT]))
    else $error("address width wrong");

  restart_ok_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    1'b1 |=> RESTART_OK == $past(s.bus_control[RESTART_BIT]))
    else $error("restart permission wrong");

  no_stop_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    s.bus_control[RESTART_BIT] |=> !STOP_START)
    else $error("stop start unexpected");

  tar_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    tar_wr_off_s |=> s.target_address == ($past(s.w_data[15:0]) & TAR_MASK))
    else $error("target write lost");

  sbyte_addr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 (SEND_STARTBYTE && $stable(s.target_address)) |-> DEST_ADDR == {3'h0, SBYTE_ADDR})
    else $error("start byte address wrong");

  plain_addr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ##1 (!s.target_address[SPECIAL_BIT] && $stable(s.target_address))
    |-> DEST_ADDR == s.target_address[9:0] && !SEND_BCAST && !SEND_STARTBYTE)
    else $error("target address wrong");

  gc_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    gc_mode |=> SEND_BCAST)
    else $error("general call dropped");

  own_match_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (!BUS_ADDR_WIDE || !s.bus_control[RESP_WIDE_BIT])
    && BUS_ADDR_SEEN[6:0] == s.own_addr[6:0] |=> SELF_MATCH)
    else $error("own address match missing");

  abort_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    s.send_abort_flag && !(do_write && s.aw_addr == RAW_EVENT_ADDR) |=> s.send_abort_flag)
    else $error("abort flag lost");

endmodule

// >>> rtl/bus_cfg_pkg.sv
package bus_cfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] BUS_CONTROL_ADDR    = 32'h5000_1400;
  localparam logic [31:0] TARGET_ADDRESS_ADDR = 32'h5000_1404;
  localparam logic [31:0] OWN_ADDR_ADDR       = 32'h5000_1408;
  localparam logic [31:0] CONTROLLER_ON_ADDR  = 32'h5000_146C;
  localparam logic [31:0] RAW_EVENT_ADDR      = 32'h5000_1434;
  localparam logic [31:0] CMD_PORT_ADDR       = 32'h5000_1410;

  // ****************************************
  // bus_control fields
  // ****************************************
  localparam int SLV_OFF_BIT   = 6;
  localparam int RESTART_BIT   = 5;
  localparam int INIT_WIDE_BIT = 4;
  localparam int RESP_WIDE_BIT = 3;
  localparam int SPEED_HI      = 2;
  localparam int SPEED_LO      = 1;
  localparam int MST_EN_BIT    = 0;
  localparam logic [15:0] CTRL_MASK  = 16'h007F;
  localparam logic [15:0] CTRL_RESET = 16'h007D;
  localparam logic [1:0]  SPEED_STD  = 2'h1;
  localparam logic [1:0]  SPEED_FAST = 2'h2;

  // ****************************************
  // target_address fields
  // ****************************************
  localparam int SPECIAL_BIT = 11;
  localparam int BCAST_BIT   = 10;
  localparam logic [15:0] TAR_MASK  = 16'h0FFF;
  localparam logic [15:0] TAR_RESET = 16'h0055;
  localparam logic [9:0]  OWN_RESET = 10'h055;
  localparam logic [6:0]  BCAST_ADDR = 7'h00;
  localparam logic [6:0]  SBYTE_ADDR = 7'h01;
  localparam int ABORT_BIT = 6;
  localparam int CMD_READ_BIT = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> test/bus_peer.sv
`timescale 1ns/1ps
// ****************************************
// far side bus stand-in
// ****************************************
module bus_peer (
  input  wire logic       clk,
  input  wire logic       want,
  input  wire logic [9:0] adr,
  input  wire logic       wid,
  output logic            restart_req,
  output logic [9:0]      addr_seen,
  output logic            addr_wide
);
  // presents what the bus shows, one edge late
  always_ff @(posedge clk) begin
    restart_req <= want;
    addr_seen   <= adr;
    addr_wide   <= wid;
  end
endmodule

// >>> test/bus_cfg_tb.sv
`timescale 1ns/1ps
module bus_cfg_tb;
  import bus_cfg_pkg::*;
  logic        clk, nrst, awv, wv, bry, arv, rry, want, wid, awr, wr_r, bv, arr, rv;
  logic        rq, sw, s_on, m_on, r_ok, st_st, m_w, s_w, bc, sb, sm, spx;
  logic [31:0] awa, wd, ara, rdat, d, v, ctrl, tar;
  logic [9:0]  adr, seen, dest;
  logic [1:0]  bresp, rresp, spd;
  int          err_total, tests_run;
  bus_cfg bus_cfg_i (.REF_CLK(clk), .NRST(nrst), .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
    .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wr_r), .BRESP(bresp), .BVALID(bv),
    .BREADY(bry), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdat), .RRESP(rresp),
    .RVALID(rv), .RREADY(rry), .RESTART_REQ(rq), .BUS_ADDR_SEEN(seen), .BUS_ADDR_WIDE(sw),
    .SLAVE_ON(s_on), .MASTER_ON(m_on), .RESTART_OK(r_ok), .STOP_START(st_st),
    .MASTER_WIDE(m_w), .SLAVE_WIDE(s_w), .SPEED_MODE(spd), .DEST_ADDR(dest),
    .SEND_BCAST(bc), .SEND_STARTBYTE(sb), .SELF_MATCH(sm), .SIMPLEX_ONLY(spx));
  bus_peer bus_peer_i (.clk(clk), .want(want), .adr(adr), .wid(wid),
    .restart_req(rq), .addr_seen(seen), .addr_wide(sw));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dd, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd  <= dd;
    awv <= 1'h1;
    wv  <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr_r) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] q);
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    q = rdat;
    rry <= 1'h0;
    chk(rresp, er);
  endtask
  task automatic outs();
    repeat (3) @(posedge clk);
    chk(s_on, !ctrl[6]);
    chk(m_on, ctrl[0]);
    chk(r_ok, ctrl[5]);
    chk(m_w, ctrl[4]);
    chk(s_w, ctrl[3]);
    chk(spd, ctrl[2:1]);
    chk(dest, !tar[11] ? tar[9:0] : {9'h000, tar[10]});
    chk(bc, tar[11] & !tar[10]);
    chk(sb, tar[11] & tar[10]);
    chk(spx, ctrl[0] && !tar[11] && tar[9:0] == 10'h055);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    {nrst, awv, wv, bry, arv, rry, want, wid} = 8'h00;
    {awa, wd, ara, adr} = '0;
    err_total = 0;
    tests_run = 0;
    ctrl = 32'h0000_007D;
    tar  = 32'h0000_0055;
    d = $urandom(32'he031_8827);
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rd(BUS_CONTROL_ADDR, RESP_OKAY, v);
    chk(v, ctrl);
    rd(TARGET_ADDRESS_ADDR, RESP_OKAY, v);
    chk(v, tar);
    outs();
    repeat (6) begin
      d = $urandom;
      d[2:1] = d[1] ? SPEED_FAST : SPEED_STD;
      if (!d[6]) d[0] = 1'h0;
      if (d[0]) d[6] = 1'h1;
      wr(BUS_CONTROL_ADDR, d, RESP_OKAY);
      ctrl = d & 32'h0000_007F;
      rd(BUS_CONTROL_ADDR, RESP_OKAY, v);
      chk(v, ctrl);
      outs();
    end
    for (int i = 0; i < 4; i++) begin
      d = ($urandom & 32'hFFFF_F3FF) | (i << 10);
      wr(TARGET_ADDRESS_ADDR, d, RESP_OKAY);
      tar = d & 32'h0000_0FFF;
      rd(TARGET_ADDRESS_ADDR, RESP_OKAY, v);
      chk(v, tar);
      outs();
    end
    for (int i = 0; i < 2; i++) begin
      ctrl = 32'h0000_005D | (i << 5);
      wr(BUS_CONTROL_ADDR, ctrl, RESP_OKAY);
      want <= 1'h1;
      outs();
      chk(st_st, !ctrl[5]);
    end
    want <= 1'h0;
    ctrl = 32'h0000_0034;
    wr(BUS_CONTROL_ADDR, ctrl, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      adr <= i ? 10'h056 : 10'h255;
      repeat (3) @(posedge clk);
      chk(sm, i == 0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(TARGET_ADDRESS_ADDR, i == 2 ? 32'h0000_0055 : 32'h0000_0800, RESP_OKAY);
      wr(CMD_PORT_ADDR, i == 1 ? 32'h0000_0000 : 32'h0000_0100, RESP_OKAY);
      rd(RAW_EVENT_ADDR, RESP_OKAY, v);
      chk(v[6], i == 0);
      wr(RAW_EVENT_ADDR, 32'h0000_0040, RESP_OKAY);
    end
    tar = 32'h0000_0055;
    ctrl = 32'h0000_005D;
    wr(BUS_CONTROL_ADDR, ctrl, RESP_OKAY);
    wr(CONTROLLER_ON_ADDR, 32'h0000_0001, RESP_OKAY);
    wr(TARGET_ADDRESS_ADDR, 32'h0000_0123, RESP_OKAY);
    rd(TARGET_ADDRESS_ADDR, RESP_OKAY, v);
    chk(v, tar);
    wr(CONTROLLER_ON_ADDR, 32'h0000_0000, RESP_OKAY);
    outs();
    wr(32'h5000_1480, 32'h0000_0000, RESP_SLVERR);
    rd(32'h5000_14F0, RESP_SLVERR, v);
    summarize();
  end
endmodule
